// >>> verilog/prox_scan_pkg.sv
/*
  constants and carrier types for the proximity scan sequencer.
  assumes a 250 MHz system clock and a front end that reports one result per scan.
*/
package prox_scan_pkg;

  // system clock
  localparam int unsigned CLK_MHZ = 250;

  // sleep intervals in ms, the shortest of each allowed range
  localparam int unsigned SLEEP_NORMAL_MS = 69;
  localparam int unsigned SLEEP_LOWPOWER_MS = 572;

  // sleep intervals in clock cycles
  localparam logic [31:0] SLEEP_NORMAL_CYCLES = 32'(SLEEP_NORMAL_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] SLEEP_LOWPOWER_CYCLES = 32'(SLEEP_LOWPOWER_MS * 1000 * CLK_MHZ);

  // width of the digitised sensitivity level and of the sleep counter
  localparam int unsigned SENS_W = 4;
  localparam int unsigned TIMER_W = 32;

  // reset values
  localparam logic [SENS_W-1:0] SENS_RESET = 4'h0;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0000_0000;

  // scan result delivered by the analog front end
  typedef struct packed {
    logic proximity;
    logic touch;
  } scan_result_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_START,
    ST_SCAN,
    ST_SLEEP
  } seq_state_t;

endpackage

// >>> verilog/sleep_timer.sv
/*
  down-counting sleep interval timer.
  assumes the caller loads it once per sleep and watches the expired level.
*/
`timescale 1ns/100ps
module sleep_timer (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // load request and count
  input wire logic load_in,
  input wire logic [prox_scan_pkg::TIMER_W-1:0] count_in,
  // expiry level
  output logic expired_out
);

  logic [prox_scan_pkg::TIMER_W-1:0] count_reg;

  // load wins over the decrement so a new interval never inherits a stale count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= prox_scan_pkg::TIMER_RESET;
    end else if (ce_in) begin
      if (load_in) begin
        count_reg <= count_in;
      end else if (count_reg != prox_scan_pkg::TIMER_RESET) begin
        count_reg <= count_reg - 32'h0000_0001;
      end
    end
  end

  assign expired_out = (count_reg == prox_scan_pkg::TIMER_RESET);

endmodule

// >>> verilog/proximity_scan_sequencer.sv
/*
  scan and sleep sequencer of a single-channel capacitive proximity detector.
  assumes a front end that starts a scan on a pulse and answers with one done pulse
  and a result; the mode pin and sensitivity level are synchronous to the clock.
*/
// Behaviour
// - with the mode pin high and no detection, sleep a normal interval after each scan.
// - with the mode pin low and no detection, sleep the long low-power interval after each scan.
// - while something is detected, scans run back to back with no sleep.
// - once detection is released, the sleep schedule of the current pin mode resumes.
// - the sensitivity level is re-sampled after every scan and used by the next one.
// - a level at supply means lowest sensitivity, a level at ground the highest.
// - any edge of the mode pin resets detection and clears the detected state.
// - the mode pin reset is accepted at any time, not only while detected.
// - a touch followed by a release clears a persistent detected state.
// - the detect pin is driven low while detected and released otherwise, open-drain.
`timescale 1ns/100ps
module proximity_scan_sequencer #(
  parameter logic [31:0] NORMAL_SLEEP_CYCLES = prox_scan_pkg::SLEEP_NORMAL_CYCLES,
  parameter logic [31:0] LOWPOWER_SLEEP_CYCLES = prox_scan_pkg::SLEEP_LOWPOWER_CYCLES
) (
  // clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  // host side pins
  input wire logic LOWPOWER_SELECT_N_IN,
  input wire logic [prox_scan_pkg::SENS_W-1:0] SENSITIVITY_LEVEL_IN,
  output logic DETECT_OUT_N_OUT,
  output logic DETECT_OE_OUT,
  // analog front end of the sense input
  output logic SCAN_START_OUT,
  output logic FRONTEND_RESET_OUT,
  output logic [prox_scan_pkg::SENS_W-1:0] SENSITIVITY_OUT,
  input wire logic SCAN_DONE_IN,
  input wire prox_scan_pkg::scan_result_t SENSE_RESULT_IN
);

  prox_scan_pkg::seq_state_t state_reg;
  prox_scan_pkg::seq_state_t state_next;
  logic mode_prev_reg;
  logic detected_reg;
  logic touch_seen_reg;
  logic frontend_reset_reg;
  logic [prox_scan_pkg::SENS_W-1:0] sens_reg;
  logic mode_edge;
  logic scan_hit;
  logic sleep_load;
  logic sleep_expired;
  logic [31:0] sleep_count;

  // map the pin level to a sensitivity: full scale is least sensitive
  function automatic logic [prox_scan_pkg::SENS_W-1:0] level_to_sens(
    input logic [prox_scan_pkg::SENS_W-1:0] level
  );
    level_to_sens = ~level;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode pin edge detect
  //////////////////////////////////////////////////////////////////////////////

  // previous pin level, reset high; a pin held high gives no edge after reset, one held low gives one
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_prev_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      mode_prev_reg <= LOWPOWER_SELECT_N_IN;
    end
  end

  // either direction counts, so the host can pulse without changing mode
  assign mode_edge = (LOWPOWER_SELECT_N_IN != mode_prev_reg);
  assign scan_hit = SENSE_RESULT_IN.proximity | SENSE_RESULT_IN.touch;

  //////////////////////////////////////////////////////////////////////////////
  // scan and sleep sequencing
  //////////////////////////////////////////////////////////////////////////////

  // next state; a pin edge restarts scanning from any state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      prox_scan_pkg::ST_START: begin
        state_next = prox_scan_pkg::ST_SCAN;
      end
      prox_scan_pkg::ST_SCAN: begin
        if (SCAN_DONE_IN) begin
          if (detected_reg || scan_hit) begin
            state_next = prox_scan_pkg::ST_START;
          end else begin
            state_next = prox_scan_pkg::ST_SLEEP;
          end
        end
      end
      prox_scan_pkg::ST_SLEEP: begin
        if (sleep_expired) begin
          state_next = prox_scan_pkg::ST_START;
        end
      end
      default: begin
        state_next = prox_scan_pkg::ST_START;
      end
    endcase
    if (mode_edge) begin
      state_next = prox_scan_pkg::ST_START;
    end
  end

  // state register
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= prox_scan_pkg::ST_START;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
    end
  end

  // load the sleep counter on the way into sleep, length by current pin mode
  assign sleep_load = (state_reg == prox_scan_pkg::ST_SCAN) &&
                      (state_next == prox_scan_pkg::ST_SLEEP);
  assign sleep_count = LOWPOWER_SELECT_N_IN ? NORMAL_SLEEP_CYCLES
                                            : LOWPOWER_SLEEP_CYCLES;

  sleep_timer u_sleep_timer (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CLK_EN_IN),
    .load_in(sleep_load),
    .count_in(sleep_count),
    .expired_out(sleep_expired)
  );

  //////////////////////////////////////////////////////////////////////////////
  // detection and stuck release
  //////////////////////////////////////////////////////////////////////////////

  // detected state; a pin edge overrides whatever the scan reports
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      detected_reg <= 1'b0;
      touch_seen_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (mode_edge) begin
        detected_reg <= 1'b0;
        touch_seen_reg <= 1'b0;
      end else if (SCAN_DONE_IN && state_reg == prox_scan_pkg::ST_SCAN) begin
        if (detected_reg && touch_seen_reg && !SENSE_RESULT_IN.touch) begin
          detected_reg <= 1'b0;
          touch_seen_reg <= 1'b0;
        end else begin
          detected_reg <= scan_hit;
          touch_seen_reg <= (detected_reg | scan_hit) & (touch_seen_reg | SENSE_RESULT_IN.touch);
        end
      end
    end
  end

  // front end reset pulse so baselines restart after a pin edge
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frontend_reset_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      frontend_reset_reg <= mode_edge;
    end
  end

  // sensitivity sampled once per finished scan, held for the next scan
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sens_reg <= prox_scan_pkg::SENS_RESET;
    end else if (CLK_EN_IN && SCAN_DONE_IN && state_reg == prox_scan_pkg::ST_SCAN) begin
      sens_reg <= level_to_sens(SENSITIVITY_LEVEL_IN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  //////////////////////////////////////////////////////////////////////////////

  // open drain: only ever pull low, release the pin otherwise
  assign DETECT_OUT_N_OUT = 1'b0;
  assign DETECT_OE_OUT = detected_reg;
  assign SCAN_START_OUT = (state_reg == prox_scan_pkg::ST_START) && CLK_EN_IN;
  assign FRONTEND_RESET_OUT = frontend_reset_reg;
  assign SENSITIVITY_OUT = sens_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  //////////////////////////////////////////////////////////////////////////////

  logic touch_armed_reg;
  logic scan_taken;

  // a finished scan that the sequencer actually accepts
  assign scan_taken = SCAN_DONE_IN && (state_reg == prox_scan_pkg::ST_SCAN);

  // helper: the latest accepted scan reported a touch while detected;
  // any later scan or a pin edge disarms it, so only the next scan is judged
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      touch_armed_reg <= 1'b0;
    end else if (CLK_EN_IN && (mode_edge || scan_taken)) begin
      touch_armed_reg <= !mode_edge && detected_reg && SENSE_RESULT_IN.touch;
    end
  end

  sequence scan_done_s;
    CLK_EN_IN && SCAN_DONE_IN && state_reg == prox_scan_pkg::ST_SCAN && !mode_edge;
  endsequence

  sequence touched_s;
    scan_done_s ##0 detected_reg && SENSE_RESULT_IN.touch;
  endsequence

  sequence released_s;
    scan_done_s ##0 !SENSE_RESULT_IN.touch;
  endsequence

  detect_drive_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    DETECT_OE_OUT == detected_reg && !DETECT_OUT_N_OUT)
    else $error("detect pin not tied to detected state");

  pin_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    CLK_EN_IN && mode_edge |=> !detected_reg && FRONTEND_RESET_OUT)
    else $error("pin edge did not clear detection");

  no_sleep_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    scan_done_s ##0 (detected_reg || scan_hit) |=> state_reg == prox_scan_pkg::ST_START)
    else $error("sleep entered while detected");

  resume_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    scan_done_s ##0 (!detected_reg && !scan_hit) |=> state_reg == prox_scan_pkg::ST_SLEEP)
    else $error("schedule not resumed");

  normal_len_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    sleep_load && LOWPOWER_SELECT_N_IN |-> sleep_count == NORMAL_SLEEP_CYCLES)
    else $error("normal sleep length wrong");

  lowpower_len_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    sleep_load && !LOWPOWER_SELECT_N_IN |-> sleep_count == LOWPOWER_SLEEP_CYCLES)
    else $error("low power sleep length wrong");

  sens_sample_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    scan_done_s |=> SENSITIVITY_OUT == ~$past(SENSITIVITY_LEVEL_IN))
    else $error("sensitivity not resampled");

  sleep_wake_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    CLK_EN_IN && state_reg == prox_scan_pkg::ST_SLEEP && mode_edge
    |=> state_reg == prox_scan_pkg::ST_START ##1 state_reg == prox_scan_pkg::ST_SCAN)
    else $error("pin edge did not end sleep");

  detect_set_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    scan_done_s ##0 !detected_reg && scan_hit |=> DETECT_OE_OUT && !DETECT_OUT_N_OUT)
    else $error("new detection did not pull the pin");

  touch_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    touched_s |=> detected_reg)
    else $error("touch did not hold detection");

  stuck_release_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    touch_armed_reg ##0 released_s |=> !detected_reg)
    else $error("touch and release did not clear");

endmodule

// >>> sim/frontend_model.sv
/*
  behavioural analog front end and pulled-up detect pin for the sequencer bench.
  assumes one start pulse per scan and a result set by the bench before done.
*/
`timescale 1ns/100ps
module frontend_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // scan handshake
  input wire logic start_in,
  input wire prox_scan_pkg::scan_result_t res_in,
  output logic done_out,
  output prox_scan_pkg::scan_result_t result_out,
  // detect pin drive
  input wire logic oe_in,
  input wire logic data_in,
  output wire pin_out
);
  logic [1:0] cnt_reg;
  logic busy_reg;
  //////////////////////////////////////////////////////////////////
  // scan takes three cycles; a new start restarts it, as after a mode reset
  // result toggles outside done so a stale value never looks valid
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b0;
      cnt_reg <= 2'h0;
      done_out <= 1'b0;
      result_out <= 2'h0;
    end else begin
      done_out <= 1'b0;
      result_out <= ~result_out;
      if (start_in) begin
        busy_reg <= 1'b1;
        cnt_reg <= 2'h2;
      end else if (busy_reg) begin
        if (cnt_reg == 2'h0) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
          result_out <= res_in;
        end else begin
          cnt_reg <= cnt_reg - 2'h1;
        end
      end
    end
  end
  // external pull-up holds the pin high when released
  assign pin_out = oe_in ? data_in : 1'b1;
endmodule

// >>> sim/tb.sv
/*
  self-checking bench of the proximity scan sequencer.
  assumes short sleep parameters of 20 and 50 cycles.
*/
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic mode_n = 1'b1;
  logic [3:0] sens = 4'h0;
  prox_scan_pkg::scan_result_t res = 2'h0;
  prox_scan_pkg::scan_result_t result;
  logic done, oe, dn, start, fe_rst;
  logic [3:0] sens_o;
  wire pin;
  int num_errors = 0;
  int checks = 0;
  int g;
  //////////////////////////////////////////////////////////////////
  proximity_scan_sequencer #(.NORMAL_SLEEP_CYCLES(32'h14), .LOWPOWER_SLEEP_CYCLES(32'h32))
  u_proximity_scan_sequencer (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(en),
    .LOWPOWER_SELECT_N_IN(mode_n), .SENSITIVITY_LEVEL_IN(sens), .DETECT_OUT_N_OUT(dn),
    .DETECT_OE_OUT(oe), .SCAN_START_OUT(start), .FRONTEND_RESET_OUT(fe_rst),
    .SENSITIVITY_OUT(sens_o), .SCAN_DONE_IN(done), .SENSE_RESULT_IN(result));
  frontend_model u_frontend_model (.clk_in(clk), .rst_n_in(rst_n), .start_in(start),
    .res_in(res), .done_out(done), .result_out(result), .oe_in(oe), .data_in(dn),
    .pin_out(pin));
  // clock of 4 ns
  initial forever #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////
  // shared compare, wait and closing tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded waits so a stuck design fails the gap check rather than hangs
  task wait_done;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 200);
  endtask
  task gap(output int c);
    wait_done();
    c = 0;
    do begin @(posedge clk); c++; end while (start !== 1'b1 && c < 200);
  endtask
  //////////////////////////////////////////////////////////////////
  // sleep length in both modes, detection keeps scans back to back
  task t_sleep;
    gap(g);
    gap(g);
    check("normal gap", g >= 20 && g <= 24, 1);
    mode_n <= 1'b0;
    gap(g);
    gap(g);
    check("lowpower gap", g >= 50 && g <= 54, 1);
    res <= 2'h2;
    gap(g);
    gap(g);
    check("detect gap", g <= 3, 1);
    res <= 2'h0;
    #1 check("detect oe", oe, 1);
    check("detect pin", pin, 0);
    // the scan that clears detection is still followed straight by another
    gap(g);
    check("release rescan", g <= 3, 1);
    gap(g);
    check("release gap", g >= 50 && g <= 54, 1);
    check("release pin", pin, 1);
    $display("test sleep done");
  endtask
  // mode pin edge while detected and a same-mode pulse during sleep
  task t_mode;
    res <= 2'h2;
    wait_done();
    #1 check("pre oe", oe, 1);
    @(posedge clk) mode_n <= 1'b1;
    @(posedge clk) res <= 2'h0;
    #1 check("edge oe", oe, 0);
    check("edge fe reset", fe_rst, 1);
    wait_done();
    repeat (4) @(posedge clk);
    mode_n <= 1'b0;
    @(posedge clk) #1 check("sleep fe reset", fe_rst, 1);
    check("sleep ends", start, 1);
    // pulse held past reset time plus sleep, scaled
    repeat (25) @(posedge clk);
    mode_n <= 1'b1;
    @(posedge clk) #1 check("pulse end fe reset", fe_rst, 1);
    $display("test mode done");
  endtask
  // touch then release clears detection though proximity remains
  task t_stuck;
    @(posedge clk) res <= 2'h2;
    wait_done();
    res <= 2'h3;
    wait_done();
    res <= 2'h2;
    #1 check("touch oe", oe, 1);
    wait_done();
    #1 check("release oe", oe, 0);
    $display("test stuck done");
  endtask
  // sensitivity level follows each scan, inverted
  task t_sens;
    @(posedge clk) res <= 2'h2;
    sens <= 4'hf;
    wait_done();
    wait_done();
    sens <= 4'h0;
    #1 check("sens high", sens_o, 4'h0);
    wait_done();
    res <= 2'h0;
    #1 check("sens low", sens_o, 4'hf);
    $display("test sens done");
  endtask
  // clock enable low during sleep freezes the tick counter, so the gap grows
  task t_hold;
    int c;
    wait_done();
    wait_done();
    en <= 1'b0;
    repeat (10) @(posedge clk);
    en <= 1'b1;
    c = 0;
    do begin @(posedge clk); c++; end while (start !== 1'b1 && c < 200);
    check("frozen sleep", c >= 20 && c <= 24, 1);
    $display("test hold done");
  endtask
  //////////////////////////////////////////////////////////////////
  // reset for five cycles, then the tests
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    t_sleep();
    t_mode();
    t_stuck();
    t_sens();
    t_hold();
    results();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end
endmodule
